// file: core/hbcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module hbcs_sequencer (
  input wire logic clock,
  input wire logic reset,
  input wire hbcs_pkg::hbcs_pin_s pins,
  input wire logic flash_rd_ack,
  input wire logic [7:0] flash_rd_data,
  input wire logic legacy_mode,
  input wire logic smb_wr,
  input wire logic [7:0] smb_wr_reg,
  input wire logic [7:0] smb_wr_data,
  input wire logic smb_cmd,
  input wire logic [15:0] smb_cmd_code,
  input wire hbcs_pkg::hbcs_cfg_s otp_cfg,
  input wire logic [9:0] otp_mask,
  output hbcs_pkg::hbcs_stage_e stage_r,
  output logic pll_lock_r,
  output logic flash_rd_req_r,
  output logic [23:0] flash_rd_addr_r,
  output logic flash_boot_r,
  output logic [23:0] flash_exec_addr_r,
  output logic usb2_attach_r,
  output logic superspeed_hub_on_r,
  output logic smbus_retain_r,
  output hbcs_pkg::hbcs_cfg_s cfg_r,
  output logic [6:0] phys_port_oe_r
);

  hbcs_pkg::hbcs_pin_s meta_r;
  hbcs_pkg::hbcs_pin_s pin_r;

  // two-stage synchroniser; only pin_r is looked at
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      pin_r <= '0;
    end else begin
      meta_r <= pins;
      pin_r <= meta_r;
    end
  end

  hbcs_pkg::hbcs_stage_e stage_nxt;
  hbcs_pkg::hbcs_cfg_s cfg_nxt;
  logic pll_lock_nxt;
  logic flash_rd_req_nxt;
  logic [23:0] flash_rd_addr_nxt;
  logic flash_boot_nxt;
  logic [23:0] flash_exec_addr_nxt;
  logic usb2_attach_nxt;
  logic superspeed_hub_on_nxt;
  logic smbus_retain_nxt;
  logic [6:0] phys_port_oe_nxt;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic sig_ok_r;
  logic sig_ok_nxt;
  logic [7:0] sig_byte;
  logic smb_end;
  logic [4:0] log_en;

  always_comb begin
    stage_nxt = stage_r;
    cfg_nxt = cfg_r;
    pll_lock_nxt = pll_lock_r;
    flash_rd_req_nxt = flash_rd_req_r;
    flash_boot_nxt = flash_boot_r;
    flash_exec_addr_nxt = flash_exec_addr_r;
    usb2_attach_nxt = usb2_attach_r;
    superspeed_hub_on_nxt = superspeed_hub_on_r;
    smbus_retain_nxt = smbus_retain_r;
    idx_nxt = idx_r;
    sig_ok_nxt = sig_ok_r;
    // first byte of the signature sits at the lowest address
    sig_byte = 8'(hbcs_pkg::SIG_WORD >> {~idx_r, 3'h0});
    smb_end = legacy_mode ? (smb_wr && smb_wr_reg == hbcs_pkg::SMB_END_REG) :
      (smb_cmd && (smb_cmd_code == hbcs_pkg::CMD_ATTACH ||
                   smb_cmd_code == hbcs_pkg::CMD_ATTACH_SMB));
    case (stage_r)
      hbcs_pkg::HBCS_STANDBY: begin
        stage_nxt = hbcs_pkg::HBCS_FLASH_INIT;
      end
      hbcs_pkg::HBCS_FLASH_INIT: begin
        if (pin_r.clock_valid) begin
          pll_lock_nxt = 1'b1;
        end
        // lock needs clock_valid through both synchroniser flops, so the straps have settled too
        if (!pll_lock_r) begin
          stage_nxt = hbcs_pkg::HBCS_FLASH_INIT;
        end else if (!pin_r.flash_boot_strap) begin
          stage_nxt = hbcs_pkg::HBCS_ROM_CFG;
        end else begin
          // the flash reader on this clock may take any number of cycles
          flash_rd_req_nxt = 1'b1;
          if (flash_rd_req_r && flash_rd_ack) begin
            flash_rd_req_nxt = 1'b0;
            sig_ok_nxt = sig_ok_r && (flash_rd_data == sig_byte);
            idx_nxt = idx_r + 2'h1;
            if (idx_r == hbcs_pkg::SIG_LAST) begin
              if (sig_ok_nxt) begin
                flash_boot_nxt = 1'b1;
                flash_exec_addr_nxt = hbcs_pkg::EXEC_ADDR;
                stage_nxt = hbcs_pkg::HBCS_STRAP_READ;
              end else begin
                stage_nxt = hbcs_pkg::HBCS_ROM_CFG;
              end
            end
          end
        end
      end
      hbcs_pkg::HBCS_ROM_CFG: begin
        cfg_nxt = hbcs_pkg::ROM_DEFAULT;
        stage_nxt = hbcs_pkg::HBCS_STRAP_READ;
      end
      hbcs_pkg::HBCS_STRAP_READ: begin
        cfg_nxt.dis_plus = pin_r.port_disable_plus_straps;
        cfg_nxt.dis_minus = pin_r.port_disable_minus_straps;
        cfg_nxt.non_rem = pin_r.non_removable_strap;
        cfg_nxt.bc_en = pin_r.battery_charge_strap;
        if (pin_r.cfg_strap == hbcs_pkg::STRAP_CFG1) begin
          stage_nxt = hbcs_pkg::HBCS_SMB_CHECK;
        end else begin
          stage_nxt = hbcs_pkg::HBCS_OTP_MERGE;
        end
      end
      hbcs_pkg::HBCS_SMB_CHECK: begin
        if (pin_r.smb_clk_pullup && pin_r.smb_dat_pullup) begin
          stage_nxt = hbcs_pkg::HBCS_SMB_CFG;
        end else begin
          stage_nxt = hbcs_pkg::HBCS_OTP_MERGE;
        end
      end
      hbcs_pkg::HBCS_SMB_CFG: begin
        // no timer here: the master alone decides when to finish
        if (smb_end) begin
          smbus_retain_nxt = !legacy_mode && smb_cmd_code == hbcs_pkg::CMD_ATTACH_SMB;
          stage_nxt = hbcs_pkg::HBCS_OTP_MERGE;
        end else if (smb_wr && smb_wr_reg == hbcs_pkg::SMB_REG_PORT_DIS) begin
          cfg_nxt.dis_minus = smb_wr_data[7:4];
          cfg_nxt.dis_plus = smb_wr_data[3:0];
        end else if (smb_wr && smb_wr_reg == hbcs_pkg::SMB_REG_PORT_OPT) begin
          cfg_nxt.bc_en = smb_wr_data[1];
          cfg_nxt.non_rem = smb_wr_data[0];
        end
      end
      hbcs_pkg::HBCS_OTP_MERGE: begin
        cfg_nxt = (cfg_r & ~otp_mask) | (otp_cfg & otp_mask);
        stage_nxt = hbcs_pkg::HBCS_CONNECT;
      end
      hbcs_pkg::HBCS_CONNECT: begin
        usb2_attach_nxt = 1'b1;
        superspeed_hub_on_nxt = 1'b1;
        // a soft disconnect only clears phys_port_oe_r; the stage never leaves
      end
      default: begin
        stage_nxt = hbcs_pkg::HBCS_STANDBY;
      end
    endcase
    flash_rd_addr_nxt = hbcs_pkg::SIG_ADDR + {22'h000000, idx_nxt};
    // logical enables; logical 0 is the upstream port
    log_en[0] = 1'b1;
    for (int k = 1; k < 5; k++) begin
      log_en[k] = !(cfg_nxt.dis_plus[k-1] || cfg_nxt.dis_minus[k-1]);
    end
    if (stage_nxt == hbcs_pkg::HBCS_CONNECT && !pin_r.soft_disconnect) begin
      phys_port_oe_nxt = {1'b0, log_en[3], log_en[2], log_en[2],
                          log_en[1] || log_en[4], log_en[1], log_en[0]};
    end else begin
      phys_port_oe_nxt = 7'h00;
    end
  end

  // reset is the inverted chip reset pin: everything back to defaults
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage_r <= hbcs_pkg::HBCS_STANDBY;
      cfg_r <= hbcs_pkg::CFG_RESET;
      pll_lock_r <= 1'b0;
      flash_rd_req_r <= 1'b0;
      flash_rd_addr_r <= hbcs_pkg::SIG_ADDR;
      flash_boot_r <= 1'b0;
      flash_exec_addr_r <= hbcs_pkg::EXEC_ADDR;
      usb2_attach_r <= 1'b0;
      superspeed_hub_on_r <= 1'b0;
      smbus_retain_r <= 1'b0;
      phys_port_oe_r <= 7'h00;
      idx_r <= 2'h0;
      sig_ok_r <= 1'b1;
    end else begin
      stage_r <= stage_nxt;
      cfg_r <= cfg_nxt;
      pll_lock_r <= pll_lock_nxt;
      flash_rd_req_r <= flash_rd_req_nxt;
      flash_rd_addr_r <= flash_rd_addr_nxt;
      flash_boot_r <= flash_boot_nxt;
      flash_exec_addr_r <= flash_exec_addr_nxt;
      usb2_attach_r <= usb2_attach_nxt;
      superspeed_hub_on_r <= superspeed_hub_on_nxt;
      smbus_retain_r <= smbus_retain_nxt;
      phys_port_oe_r <= phys_port_oe_nxt;
      idx_r <= idx_nxt;
      sig_ok_r <= sig_ok_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_standby_quiet;
    stage_r == hbcs_pkg::HBCS_STANDBY |-> phys_port_oe_r == 7'h00 && !usb2_attach_r;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("ports driven in standby");

  property p_release_flash;
    stage_r == hbcs_pkg::HBCS_STANDBY |=> stage_r == hbcs_pkg::HBCS_FLASH_INIT;
  endproperty
  a_release_flash: assert property (p_release_flash)
    else $error("standby not followed by flash init");

  property p_sig_addr;
    flash_rd_req_r |-> flash_rd_addr_r >= hbcs_pkg::SIG_ADDR &&
      flash_rd_addr_r <= hbcs_pkg::SIG_ADDR + 24'h000003;
  endproperty
  a_sig_addr: assert property (p_sig_addr)
    else $error("flash read outside signature");

  property p_flash_boot;
    flash_boot_r |-> flash_exec_addr_r == hbcs_pkg::EXEC_ADDR &&
      stage_r != hbcs_pkg::HBCS_ROM_CFG;
  endproperty
  a_flash_boot: assert property (p_flash_boot)
    else $error("flash boot with rom stage");

  property p_no_strap_skip;
    stage_r == hbcs_pkg::HBCS_FLASH_INIT && pll_lock_r && !pin_r.flash_boot_strap
      |=> stage_r == hbcs_pkg::HBCS_ROM_CFG && !flash_rd_req_r;
  endproperty
  a_no_strap_skip: assert property (p_no_strap_skip)
    else $error("signature check not skipped");

  property p_strap_branch;
    stage_r == hbcs_pkg::HBCS_STRAP_READ |=>
      (stage_r == hbcs_pkg::HBCS_SMB_CHECK) == ($past(pin_r.cfg_strap) == hbcs_pkg::STRAP_CFG1);
  endproperty
  a_strap_branch: assert property (p_strap_branch)
    else $error("wrong stage after strap read");

  property p_pullups;
    stage_r == hbcs_pkg::HBCS_SMB_CHECK |=> (stage_r == hbcs_pkg::HBCS_SMB_CFG) ==
      ($past(pin_r.smb_clk_pullup) && $past(pin_r.smb_dat_pullup));
  endproperty
  a_pullups: assert property (p_pullups)
    else $error("smbus presence decision wrong");

  sequence s_smb_wait;
    stage_r == hbcs_pkg::HBCS_SMB_CFG && !smb_end;
  endsequence
  sequence s_smb_done;
    stage_r == hbcs_pkg::HBCS_SMB_CFG && smb_end;
  endsequence

  property p_smb_hold;
    s_smb_wait |=> stage_r == hbcs_pkg::HBCS_SMB_CFG;
  endproperty
  a_smb_hold: assert property (p_smb_hold)
    else $error("smbus stage left without end");

  property p_smb_end;
    s_smb_done |=> stage_r == hbcs_pkg::HBCS_OTP_MERGE ##1 stage_r == hbcs_pkg::HBCS_CONNECT;
  endproperty
  a_smb_end: assert property (p_smb_end)
    else $error("end of smbus config not taken");

  property p_otp_wins;
    stage_r == hbcs_pkg::HBCS_OTP_MERGE |=>
      ((cfg_r ^ $past(otp_cfg)) & $past(otp_mask)) == 10'h000;
  endproperty
  a_otp_wins: assert property (p_otp_wins)
    else $error("otp value lost in merge");

  property p_connect;
    stage_r == hbcs_pkg::HBCS_CONNECT |=> stage_r == hbcs_pkg::HBCS_CONNECT &&
      usb2_attach_r && superspeed_hub_on_r;
  endproperty
  a_connect: assert property (p_connect)
    else $error("attach bits missing in connect");

  property p_map;
    phys_port_oe_r != 7'h00 |-> phys_port_oe_r[0] && !phys_port_oe_r[6] &&
      phys_port_oe_r[3] == phys_port_oe_r[4] && (!phys_port_oe_r[1] || phys_port_oe_r[2]);
  endproperty
  a_map: assert property (p_map)
    else $error("port map broken");

endmodule

`default_nettype wire

// file: core/hbcs_pkg.sv
`default_nettype none
package hbcs_pkg;

  typedef enum logic [7:0] {
    HBCS_STANDBY    = 8'h01,
    HBCS_FLASH_INIT = 8'h02,
    HBCS_ROM_CFG    = 8'h04,
    HBCS_STRAP_READ = 8'h08,
    HBCS_SMB_CHECK  = 8'h10,
    HBCS_SMB_CFG    = 8'h20,
    HBCS_OTP_MERGE  = 8'h40,
    HBCS_CONNECT    = 8'h80
  } hbcs_stage_e;

  // hub configuration image that the stages build up
  typedef struct packed {
    logic [3:0] dis_plus;
    logic [3:0] dis_minus;
    logic non_rem;
    logic bc_en;
  } hbcs_cfg_s;

  // raw pins from outside the clock domain
  typedef struct packed {
    logic [2:0] cfg_strap;
    logic [3:0] port_disable_plus_straps;
    logic [3:0] port_disable_minus_straps;
    logic non_removable_strap;
    logic battery_charge_strap;
    logic flash_boot_strap;
    logic smb_clk_pullup;
    logic smb_dat_pullup;
    logic soft_disconnect;
    logic clock_valid;
  } hbcs_pin_s;

  localparam logic [23:0] SIG_ADDR = 24'h03fffa;
  localparam logic [31:0] SIG_WORD = 32'h32444655;
  localparam logic [23:0] EXEC_ADDR = 24'h000000;
  localparam logic [1:0] SIG_LAST = 2'h3;
  localparam logic [2:0] STRAP_CFG1 = 3'h1;
  localparam logic [7:0] SMB_END_REG = 8'hff;
  localparam logic [7:0] SMB_REG_PORT_DIS = 8'h01;
  localparam logic [7:0] SMB_REG_PORT_OPT = 8'h02;
  localparam logic [15:0] CMD_ATTACH = 16'haa55;
  localparam logic [15:0] CMD_ATTACH_SMB = 16'haa56;
  localparam hbcs_cfg_s ROM_DEFAULT = 10'h000;
  localparam hbcs_cfg_s CFG_RESET = 10'h000;
  localparam int PHYS_PORTS = 7;

endpackage
`default_nettype wire

// file: dv/hbcs_partner.sv
`timescale 1ns/1ps
`default_nettype none
module hbcs_partner (
  input wire logic clock,
  input wire logic flash_rd_req_r,
  input wire logic [23:0] flash_rd_addr_r,
  input wire logic sig_good,
  input wire logic slow,
  output logic flash_rd_ack,
  output logic [7:0] flash_rd_data,
  output logic smb_wr,
  output logic [7:0] smb_wr_reg,
  output logic [7:0] smb_wr_data,
  output logic smb_cmd,
  output logic [15:0] smb_cmd_code
);
  int cnt;
  // flash content: signature at the top, everything else reads erased
  function automatic logic [7:0] byte_at(input logic [23:0] a);
    case (a)
      24'h03fffa: byte_at = 8'h32;
      24'h03fffb: byte_at = 8'h44;
      24'h03fffc: byte_at = 8'h46;
      24'h03fffd: byte_at = sig_good ? 8'h55 : 8'h54;
      default: byte_at = 8'hff;
    endcase
  endfunction
  initial begin
    cnt = 0;
    flash_rd_ack = 1'b0;
    flash_rd_data = 8'h5a;
    {smb_wr, smb_wr_reg, smb_wr_data, smb_cmd, smb_cmd_code} = '0;
  end
  // one answer per request, late when slow; data toggles while not valid
  always @(posedge clock) begin
    #1;
    if (!flash_rd_ack && flash_rd_req_r && cnt >= (slow ? 3 : 0)) begin
      flash_rd_ack = 1'b1;
      flash_rd_data = byte_at(flash_rd_addr_r);
    end else begin
      cnt = (flash_rd_req_r && !flash_rd_ack) ? cnt + 1 : 0;
      flash_rd_ack = 1'b0;
      flash_rd_data = ~flash_rd_data;
    end
  end
  task automatic smb_write(input logic [7:0] r, input logic [7:0] d);
    @(posedge clock);
    #1;
    {smb_wr, smb_wr_reg, smb_wr_data} = {1'b1, r, d};
    @(posedge clock);
    #1;
    {smb_wr, smb_wr_reg, smb_wr_data} = {1'b0, ~r, ~d};
  endtask
  task automatic smb_command(input logic [15:0] c);
    @(posedge clock);
    #1;
    {smb_cmd, smb_cmd_code} = {1'b1, c};
    @(posedge clock);
    #1;
    {smb_cmd, smb_cmd_code} = {1'b0, ~c};
  endtask
endmodule
`default_nettype wire

// file: dv/hub_boot_config_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hub_boot_config_sequencer_tb_top;
  logic clock, reset, legacy_mode, sig_good, slow, saw_req;
  hbcs_pkg::hbcs_pin_s pins;
  hbcs_pkg::hbcs_cfg_s otp_cfg, cfg_r;
  logic [9:0] otp_mask;
  logic flash_rd_ack, smb_wr, smb_cmd, pll_lock_r, flash_rd_req_r, flash_boot_r;
  logic usb2_attach_r, superspeed_hub_on_r, smbus_retain_r;
  logic [7:0] flash_rd_data, smb_wr_reg, smb_wr_data;
  logic [15:0] smb_cmd_code;
  logic [23:0] flash_rd_addr_r, flash_exec_addr_r;
  logic [6:0] phys_port_oe_r;
  hbcs_pkg::hbcs_stage_e stage_r;
  int mismatches, tests_run;

  hbcs_sequencer uut (.clock, .reset, .pins, .flash_rd_ack, .flash_rd_data, .legacy_mode,
    .smb_wr, .smb_wr_reg, .smb_wr_data, .smb_cmd, .smb_cmd_code, .otp_cfg, .otp_mask,
    .stage_r, .pll_lock_r, .flash_rd_req_r, .flash_rd_addr_r, .flash_boot_r,
    .flash_exec_addr_r, .usb2_attach_r, .superspeed_hub_on_r, .smbus_retain_r, .cfg_r,
    .phys_port_oe_r);
  hbcs_partner far_end (.clock, .flash_rd_req_r, .flash_rd_addr_r, .sig_good, .slow,
    .flash_rd_ack, .flash_rd_data, .smb_wr, .smb_wr_reg, .smb_wr_data, .smb_cmd,
    .smb_cmd_code);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic wait_stage(input hbcs_pkg::hbcs_stage_e s);
    for (int i = 0; i < 300 && stage_r !== s; i++) begin
      saw_req |= flash_rd_req_r;
      step(1);
    end
    chk(stage_r === s, "stage not reached");
  endtask
  function automatic logic [6:0] exp_ports(input logic [3:0] p, input logic [3:0] m);
    logic [4:0] l;
    l = {~(p | m), 1'b1};
    exp_ports = {1'b0, l[3], l[2], l[2], l[1] | l[4], l[1], l[0]};
  endfunction
  task automatic boot(input logic [2:0] cs, input logic fb, input logic [1:0] pu);
    reset = 1'b1;
    step(3);
    chk(stage_r === hbcs_pkg::HBCS_STANDBY && phys_port_oe_r === 7'h00, "standby");
    chk(cfg_r === hbcs_pkg::CFG_RESET && pll_lock_r === 1'b0, "defaults");
    {pins.cfg_strap, pins.flash_boot_strap} = {cs, fb};
    {pins.smb_clk_pullup, pins.smb_dat_pullup} = pu;
    saw_req = 1'b0;
    reset = 1'b0;
    step(1);
    chk(stage_r === hbcs_pkg::HBCS_FLASH_INIT, "no flash init");
  endtask
  task automatic check_connect(input hbcs_pkg::hbcs_cfg_s c);
    wait_stage(hbcs_pkg::HBCS_CONNECT);
    step(2);
    chk(usb2_attach_r === 1'b1 && superspeed_hub_on_r === 1'b1, "attach bits");
    chk(phys_port_oe_r === exp_ports(c.dis_plus, c.dis_minus), "port map");
    chk(cfg_r === c, "config image");
    step(20);
    chk(stage_r === hbcs_pkg::HBCS_CONNECT, "left connect");
  endtask

  task automatic t_flash(input logic good, input logic slw);
    {sig_good, slow, otp_mask} = {good, slw, 10'h000};
    boot(3'h0, 1'b1, 2'b11);
    wait_stage(good ? hbcs_pkg::HBCS_STRAP_READ : hbcs_pkg::HBCS_ROM_CFG);
    chk(pll_lock_r === 1'b1 && flash_boot_r === good, "flash boot");
    if (good)
      chk(flash_exec_addr_r === hbcs_pkg::EXEC_ADDR, "exec addr");
    check_connect(hbcs_pkg::ROM_DEFAULT);
  endtask
  task automatic t_nostrap;
    boot(3'h0, 1'b0, 2'b11);
    wait_stage(hbcs_pkg::HBCS_ROM_CFG);
    chk(saw_req === 1'b0 && flash_boot_r === 1'b0, "flash read without strap");
  endtask
  task automatic t_straps;
    hbcs_pkg::hbcs_cfg_s c;
    logic [2:0] cs [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
    // no otp override here, so the image must equal the straps
    {otp_cfg, otp_mask} = '0;
    for (int k = 0; k < 4; k++) begin
      c = {4'(k * 5), 4'(k * 3), 1'(k), 1'(k >> 1)};
      {pins.port_disable_plus_straps, pins.port_disable_minus_straps} = {c.dis_plus, c.dis_minus};
      {pins.non_removable_strap, pins.battery_charge_strap} = {c.non_rem, c.bc_en};
      boot(cs[k], 1'b0, 2'b11);
      wait_stage(hbcs_pkg::HBCS_STRAP_READ);
      step(1);
      chk(stage_r === hbcs_pkg::HBCS_OTP_MERGE, "strap branch");
      check_connect(c);
    end
  endtask
  task automatic t_pullup(input logic [1:0] pu);
    boot(hbcs_pkg::STRAP_CFG1, 1'b0, pu);
    wait_stage(hbcs_pkg::HBCS_SMB_CHECK);
    step(1);
    chk(stage_r === hbcs_pkg::HBCS_OTP_MERGE, "pull-up check");
  endtask
  task automatic t_smb(input int mode);
    {pins.port_disable_plus_straps, pins.port_disable_minus_straps} = 8'h00;
    {pins.non_removable_strap, pins.battery_charge_strap, legacy_mode} = {2'b00, mode == 0};
    {otp_cfg, otp_mask} = {10'h001, 10'h041};
    boot(hbcs_pkg::STRAP_CFG1, 1'b0, 2'b11);
    wait_stage(hbcs_pkg::HBCS_SMB_CHECK);
    step(1);
    chk(stage_r === hbcs_pkg::HBCS_SMB_CFG, "smbus stage");
    far_end.smb_write(hbcs_pkg::SMB_REG_PORT_DIS, 8'ha5);
    step(1);
    chk(cfg_r === 10'h168, "smbus write 1");
    far_end.smb_write(hbcs_pkg::SMB_REG_PORT_OPT, 8'h01);
    step(1);
    chk(cfg_r === 10'h16a, "smbus write 2");
    if (mode == 0) far_end.smb_command(hbcs_pkg::CMD_ATTACH);
    else far_end.smb_write(hbcs_pkg::SMB_END_REG, 8'h00);
    step(100);
    chk(stage_r === hbcs_pkg::HBCS_SMB_CFG, "smbus left early");
    if (mode == 0) far_end.smb_write(hbcs_pkg::SMB_END_REG, 8'h00);
    else far_end.smb_command(mode == 1 ? hbcs_pkg::CMD_ATTACH : hbcs_pkg::CMD_ATTACH_SMB);
    check_connect(10'h12b);
    chk(smbus_retain_r === (mode == 2), "retain flag");
  endtask
  task automatic t_disconnect;
    pins.soft_disconnect = 1'b1;
    step(4);
    chk(phys_port_oe_r === 7'h00 && stage_r === hbcs_pkg::HBCS_CONNECT, "soft off");
    pins.soft_disconnect = 1'b0;
    step(4);
    chk(phys_port_oe_r === exp_ports(cfg_r.dis_plus, cfg_r.dis_minus), "soft on");
    reset = 1'b1;
    #2;
    chk(stage_r === hbcs_pkg::HBCS_STANDBY && usb2_attach_r === 1'b0, "async reset");
    chk(phys_port_oe_r === 7'h00 && cfg_r === hbcs_pkg::CFG_RESET, "reset clear");
    step(2);
  endtask

  task automatic complete_run;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    {reset, legacy_mode, sig_good, slow, saw_req} = 5'h10;
    {pins, otp_cfg, otp_mask} = '0;
    pins.clock_valid = 1'b1;
    {mismatches, tests_run} = '0;
    step(20);
    chk(stage_r === hbcs_pkg::HBCS_STANDBY && flash_rd_addr_r === 24'h03fffa, "reset");
    t_flash(1'b1, 1'b0);
    t_flash(1'b1, 1'b1);
    t_flash(1'b0, 1'b0);
    t_nostrap;
    t_pullup(2'b01);
    t_pullup(2'b10);
    for (int m = 0; m < 3; m++) t_smb(m);
    t_straps;
    t_disconnect;
    complete_run;
  end
  // about 800 cycles expected; cut off at 40,000
  initial begin
    #1000000;
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire
